/* rtl/scsc_pkg.sv */
// Constants for the system clock source control block.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package scsc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_OSC_CTL = 12'hf86;
  localparam logic [11:0] IDX_STATUS  = 12'hf87;
  localparam logic [11:0] IDX_MASK    = 12'hf88;
  localparam int          ADR_W       = 16;

  // Oscillator control field positions
  localparam int INT_EN_BIT = 7;
  localparam int RSVD_BIT   = 6;
  localparam int WDT_EN_BIT = 5;
  localparam int POF_EN_BIT = 4;
  localparam int WDF_EN_BIT = 3;
  localparam int SEL_HI     = 2;
  localparam int SEL_LO     = 0;

  // Oscillator control reset value
  localparam logic [7:0] OSC_CTL_RST = 8'ha0;

  // Clock source encodings
  localparam logic [2:0] SRC_INT_FAST = 3'h0;
  localparam logic [2:0] SRC_INT_SLOW = 3'h1;
  localparam logic [2:0] SRC_WDT      = 3'h3;
  localparam logic [2:0] SRC_EXT      = 3'h4;

  // Status and mask bit positions
  localparam int EV_PRI_FAIL = 0;
  localparam int EV_WDT_FAIL = 1;
  localparam int EV_BAD_SEL  = 2;
  localparam int EV_W        = 3;
  localparam logic [2:0] EV_RST = 3'h0;
endpackage

/* rtl/scsc_sync.sv */
// Three-stage synchroniser with agreement filter.
// Assumes async inputs; output changes once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module scsc_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;

  //////////////////////////////////////////////////////////////////////
  // First stage feeds only the second
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per-bit agreement filter
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_flt
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          out_q[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          out_q[i] <= s3_q[i];
        end
      end
    end
  endgenerate

  assign sync_out = out_q;
endmodule // scsc_sync
`default_nettype wire

/* rtl/scsc_top.sv */
// Oscillator control register with clock source select and fail detect.
// Assumes a classic Wishbone master and async oscillator fail flags.
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module scsc_top (
  input  wire logic                       ref_clk,
  input  wire logic                       reset_n,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [scsc_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic                       primary_osc_fail,
  input  wire logic                       watchdog_osc_fail,
  input  wire logic                       external_clock_input_pin,
  output logic                            internal_osc_enable,
  output logic                            watchdog_osc_enable,
  output logic                            int_osc_slow_rate,
  output logic [2:0]                      system_clock_source_select,
  output logic                            ext_clock_level,
  output logic                            irq
);
  logic [7:0]           osc_ctl_q;
  logic [7:0]           osc_ctl_d;
  logic [2:0]           status_q;
  logic [2:0]           status_d;
  logic [2:0]           mask_q;
  logic                 ack_q;
  logic [31:0]          rdata_q;
  logic                 irq_q;
  logic                 int_en_q;
  logic                 wdt_en_q;
  logic                 slow_q;
  logic [2:0]           src_q;
  logic                 ext_q;
  logic [2:0]           sync_v;
  logic                 pri_fail_s;
  logic                 wdt_fail_s;
  logic                 ext_s;
  logic                 pri_fail_prev_q;
  logic                 wdt_fail_prev_q;

  //////////////////////////////////////////////////////////////////////
  // Pin inputs pass the three-stage filter
  scsc_sync #(
    .W        (3)
  ) u_sync (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .async_in ({external_clock_input_pin, watchdog_osc_fail, primary_osc_fail}),
    .sync_out (sync_v)
  );

  assign pri_fail_s = sync_v[0];
  assign wdt_fail_s = sync_v[1];
  assign ext_s      = sync_v[2];

  //////////////////////////////////////////////////////////////////////
  // Bus decode; only bits 15:14 zero and word aligned addresses map
  wire        req      = wb_cyc_i && wb_stb_i;
  wire [11:0] idx      = wb_adr_i[13:2];
  wire        adr_ok   = (wb_adr_i[15:14] == 2'h0) && (wb_adr_i[1:0] == 2'h0);
  wire        hit_osc  = adr_ok && (idx == scsc_pkg::IDX_OSC_CTL);
  wire        hit_sts  = adr_ok && (idx == scsc_pkg::IDX_STATUS);
  wire        hit_msk  = adr_ok && (idx == scsc_pkg::IDX_MASK);
  // Effects land on the edge at which the master sees ack
  wire        commit   = req && ack_q;
  wire        wr_lane  = commit && wb_we_i && wb_sel_i[0];
  wire        wr_osc   = wr_lane && hit_osc;
  wire        wr_msk   = wr_lane && hit_msk;
  wire        rd_sts   = commit && !wb_we_i && hit_sts;

  // Reserved select codes are refused, field keeps old value
  wire [2:0]  wsel     = wb_dat_i[scsc_pkg::SEL_HI:scsc_pkg::SEL_LO];
  wire        sel_ok   = (wsel == scsc_pkg::SRC_INT_FAST) ||
                         (wsel == scsc_pkg::SRC_INT_SLOW) ||
                         (wsel == scsc_pkg::SRC_WDT) ||
                         (wsel == scsc_pkg::SRC_EXT);
  wire        bad_sel  = wr_osc && !sel_ok;

  //////////////////////////////////////////////////////////////////////
  // Fail events; detection only counts while enabled
  wire ev_pri = pri_fail_s && !pri_fail_prev_q &&
                osc_ctl_q[scsc_pkg::POF_EN_BIT];
  wire ev_wdt = wdt_fail_s && !wdt_fail_prev_q &&
                osc_ctl_q[scsc_pkg::WDF_EN_BIT];

  // Next control value: write first, then primary recovery overrides
  always_comb begin
    osc_ctl_d = osc_ctl_q;
    if (wr_osc) begin
      osc_ctl_d = wb_dat_i[7:0];
      osc_ctl_d[scsc_pkg::RSVD_BIT] = 1'b0;
      if (!sel_ok) begin
        osc_ctl_d[scsc_pkg::SEL_HI:scsc_pkg::SEL_LO] =
          osc_ctl_q[scsc_pkg::SEL_HI:scsc_pkg::SEL_LO];
      end
    end
    // Recovery falls back to the internal fast clock
    if (ev_pri) begin
      osc_ctl_d[scsc_pkg::INT_EN_BIT] = 1'b1;
      osc_ctl_d[scsc_pkg::SEL_HI:scsc_pkg::SEL_LO] = scsc_pkg::SRC_INT_FAST;
    end
  end

  // Sticky status: a set in the clearing cycle wins; a read clears only
  // the bits it returned, so an event landing during the read survives
  always_comb begin
    status_d = rd_sts ? (status_q & ~rdata_q[2:0]) : status_q;
    if (ev_pri) begin
      status_d[scsc_pkg::EV_PRI_FAIL] = 1'b1;
    end
    if (ev_wdt) begin
      status_d[scsc_pkg::EV_WDT_FAIL] = 1'b1;
    end
    if (bad_sel) begin
      status_d[scsc_pkg::EV_BAD_SEL] = 1'b1;
    end
  end

  // Read data mux; unmapped reads return zero
  wire [31:0] rmux = hit_osc ? {24'h0, osc_ctl_q} :
                     hit_sts ? {29'h0, status_q} :
                     hit_msk ? {29'h0, mask_q} : 32'h0;

  //////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_ctl_q <= scsc_pkg::OSC_CTL_RST;
      status_q  <= scsc_pkg::EV_RST;
      mask_q    <= scsc_pkg::EV_RST;
    end else begin
      osc_ctl_q <= osc_ctl_d;
      status_q  <= status_d;
      if (wr_msk) begin
        mask_q  <= wb_dat_i[2:0];
      end
    end
  end

  // Bus answer one cycle after the request, dropped the next
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q   <= req && !ack_q;
      rdata_q <= rmux;
    end
  end

  // Edge history for fail flags
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pri_fail_prev_q <= 1'b0;
      wdt_fail_prev_q <= 1'b0;
    end else begin
      pri_fail_prev_q <= pri_fail_s;
      wdt_fail_prev_q <= wdt_fail_s;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Oscillator and clock mux controls, all registered
  wire [2:0] cur_sel  = osc_ctl_q[scsc_pkg::SEL_HI:scsc_pkg::SEL_LO];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_en_q <= scsc_pkg::OSC_CTL_RST[scsc_pkg::INT_EN_BIT];
      wdt_en_q <= scsc_pkg::OSC_CTL_RST[scsc_pkg::WDT_EN_BIT];
      slow_q   <= 1'b0;
      src_q    <= scsc_pkg::SRC_INT_FAST;
      ext_q    <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      int_en_q <= osc_ctl_q[scsc_pkg::INT_EN_BIT];
      wdt_en_q <= osc_ctl_q[scsc_pkg::WDT_EN_BIT];
      slow_q   <= (cur_sel == scsc_pkg::SRC_INT_SLOW);
      src_q    <= cur_sel;
      // Pin level passes only while external source is chosen
      ext_q    <= ext_s && (cur_sel == scsc_pkg::SRC_EXT);
      irq_q    <= |(status_q & mask_q);
    end
  end

  assign wb_ack_o                   = ack_q;
  assign wb_dat_o                   = rdata_q;
  assign internal_osc_enable        = int_en_q;
  assign watchdog_osc_enable        = wdt_en_q;
  assign int_osc_slow_rate          = slow_q;
  assign system_clock_source_select = src_q;
  assign ext_clock_level            = ext_q;
  assign irq                        = irq_q;

  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_osc_write;
    wr_osc && sel_ok && !ev_pri;
  endsequence

  sequence s_req_start;
    req && !ack_q;
  endsequence

  a_ack_one_cycle: assert property (
    s_req_start |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse after request");

  a_int_en_follow: assert property (
    s_osc_write |=> ##1 (internal_osc_enable == $past(wb_dat_i[7], 2)))
    else $error("internal oscillator enable not following bit 7");

  a_rsvd_reads_zero: assert property (
    (commit && !wb_we_i && hit_osc) |-> (wb_dat_o[6] == 1'b0))
    else $error("reserved bit read nonzero");

  a_wdt_en_follow: assert property (
    s_osc_write |=> ##1 (watchdog_osc_enable == $past(wb_dat_i[5], 2)))
    else $error("watchdog oscillator enable not following bit 5");

  a_wdt_fail_gate: assert property (
    (!osc_ctl_q[scsc_pkg::WDF_EN_BIT] && !bad_sel && !rd_sts)
      |=> ($stable(status_q[scsc_pkg::EV_WDT_FAIL])))
    else $error("watchdog fail flagged while detect disabled");

  a_src_fast_slow: assert property (
    ($past(cur_sel) == scsc_pkg::SRC_INT_FAST) |-> (!int_osc_slow_rate &&
      system_clock_source_select == scsc_pkg::SRC_INT_FAST))
    else $error("fast internal source not selected");

  a_src_slow_rate: assert property (
    (cur_sel == scsc_pkg::SRC_INT_SLOW) |=> int_osc_slow_rate)
    else $error("slow rate not selected for code 001");

  a_src_select_out: assert property (
    (cur_sel == scsc_pkg::SRC_WDT) |=>
      (system_clock_source_select == scsc_pkg::SRC_WDT))
    else $error("watchdog source not driven");

  a_ext_gate: assert property (
    (cur_sel != scsc_pkg::SRC_EXT) |=> !ext_clock_level)
    else $error("external clock passed while not selected");

  a_bad_sel_kept: assert property (
    (bad_sel && !ev_pri) |=> ($stable(cur_sel) && status_q[scsc_pkg::EV_BAD_SEL]))
    else $error("reserved select code accepted");

  a_pri_recover: assert property (
    ev_pri |=> (cur_sel == scsc_pkg::SRC_INT_FAST) &&
      osc_ctl_q[scsc_pkg::INT_EN_BIT] ##1 internal_osc_enable)
    else $error("primary failure recovery missing");

  a_irq_level: assert property (
    (|(status_q & mask_q)) |=> irq)
    else $error("interrupt not raised for unmasked status");

  a_read_clears: assert property (
    (rd_sts && !ev_pri && !ev_wdt && !bad_sel) |=>
      (status_q == ($past(status_q) & ~$past(wb_dat_o[2:0]))))
    else $error("status not cleared by read");

  // Fail events land in status, and only while detection is on
  a_pri_fail_gate: assert property (
    (!osc_ctl_q[scsc_pkg::POF_EN_BIT] && !rd_sts)
      |=> ($stable(status_q[scsc_pkg::EV_PRI_FAIL])))
    else $error("primary fail flagged while detect disabled");

  a_pri_fail_sets: assert property (
    ev_pri |=> status_q[scsc_pkg::EV_PRI_FAIL])
    else $error("primary fail event not recorded");

  a_wdt_fail_sets: assert property (
    ev_wdt |=> status_q[scsc_pkg::EV_WDT_FAIL])
    else $error("watchdog fail event not recorded");

  // A clean control write lands whole, with the reserved bit cleared
  a_ctl_write_lands: assert property (
    s_osc_write |=> (!osc_ctl_q[scsc_pkg::RSVD_BIT] &&
      ({osc_ctl_q[7], osc_ctl_q[5:0]} == {$past(wb_dat_i[7]), $past(wb_dat_i[5:0])})))
    else $error("control write did not land");

  sequence s_ctl_lane_off;
    commit && wb_we_i && !wb_sel_i[0] && hit_osc && !ev_pri;
  endsequence

  a_lane_off_keeps: assert property (
    s_ctl_lane_off |=> $stable(osc_ctl_q))
    else $error("control written with byte lane off");

  a_mask_write: assert property (
    wr_msk |=> (mask_q == $past(wb_dat_i[2:0])))
    else $error("mask write did not land");

  a_mask_hold: assert property (
    !wr_msk |=> $stable(mask_q))
    else $error("mask changed without a write");

  // Bus answers only to requests, with unused read bits zero
  a_ack_needs_req: assert property (
    !req |=> !wb_ack_o)
    else $error("ack without request");

  a_rdata_upper_zero: assert property (
    wb_ack_o |-> (wb_dat_o[31:8] == 24'h0))
    else $error("upper read data bits nonzero");

  a_unmapped_zero: assert property (
    (commit && !wb_we_i && !hit_osc && !hit_sts && !hit_msk) |-> (wb_dat_o == 32'h0))
    else $error("unmapped read returned data");

  // Output side of the clock source select and interrupt
  a_slow_rate_off: assert property (
    (cur_sel != scsc_pkg::SRC_INT_SLOW) |=> !int_osc_slow_rate)
    else $error("slow rate set for another code");

  a_src_ext_out: assert property (
    (cur_sel == scsc_pkg::SRC_EXT) |=>
      (system_clock_source_select == scsc_pkg::SRC_EXT))
    else $error("external source not driven");

  a_ext_follow: assert property (
    (cur_sel == scsc_pkg::SRC_EXT) |=> (ext_clock_level == $past(ext_s)))
    else $error("external pin level not passed");

  a_irq_low: assert property (
    !(|(status_q & mask_q)) |=> !irq)
    else $error("interrupt raised with nothing unmasked");
endmodule // scsc_top
`default_nettype wire

/* tb/scsc_testbench.sv */
// Self-checking bench for the oscillator control block.
// Assumes scsc_top and scsc_pkg compiled first; one 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  typedef struct packed {logic [7:0] wr; logic [7:0] rd; logic [5:0] outs;} scsc_row_s;
  logic        ref_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic [15:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        primary_osc_fail, watchdog_osc_fail, external_clock_input_pin;
  logic        internal_osc_enable, watchdog_osc_enable, int_osc_slow_rate, ext_clock_level;
  logic [2:0]  system_clock_source_select;
  logic [5:0]  outs;
  int          err_total, n_tests, ticks;
  scsc_row_s   rows [5];
  logic [2:0]  bad_codes [4];
  localparam logic [15:0] A_CTL = 16'h3e18, A_STA = 16'h3e1c, A_MSK = 16'h3e20;
  assign outs = {internal_osc_enable, watchdog_osc_enable, int_osc_slow_rate,
                 system_clock_source_select};

  scsc_top u_scsc_top (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .primary_osc_fail(primary_osc_fail), .watchdog_osc_fail(watchdog_osc_fail),
    .external_clock_input_pin(external_clock_input_pin),
    .internal_osc_enable(internal_osc_enable), .watchdog_osc_enable(watchdog_osc_enable),
    .int_osc_slow_rate(int_osc_slow_rate),
    .system_clock_source_select(system_clock_source_select),
    .ext_clock_level(ext_clock_level), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; ceiling far above the few hundred cycles used
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    ticks <= ticks + 1;
    if (ticks == 5000) begin
      err_total++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Classic cycle; held until ack is sampled, then one idle cycle follows
  task automatic wb(input logic we, input logic [15:0] adr, input logic [7:0] d,
                    input logic [3:0] sel, output logic [31:0] q);
    @(posedge ref_clk);
    chk(wb_ack_o, 1'b0, "ack idle before request");
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1); // Only the bench timeout ends a wait
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] adr, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, adr, d, 4'hf, q);
  endtask
  task automatic rd(input logic [15:0] adr, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, adr, 8'h00, 4'hf, q);
    chk(q, exp, "read data");
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {err_total, n_tests, ticks} = '0;
    reset_n = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, primary_osc_fail, watchdog_osc_fail} = '0;
    external_clock_input_pin = 1'b0;
    wb_adr_i = 16'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    // Control writes: data, readback, {int en, wdt en, slow, select}
    rows[0] = '{8'h41, 8'h01, 6'h09}; // bit 6 dropped, slow rate
    rows[1] = '{8'ha3, 8'ha3, 6'h33}; // watchdog source
    rows[2] = '{8'h24, 8'h24, 6'h14}; // external source
    rows[3] = '{8'hff, 8'hbc, 6'h34}; // reserved code keeps select
    rows[4] = '{8'h88, 8'h88, 6'h20}; // fast internal source
    bad_codes = '{3'h2, 3'h5, 3'h6, 3'h7};
    repeat (12) @(posedge ref_clk);
    chk(outs, 6'h30, "reset outputs");
    chk({ext_clock_level, irq, wb_ack_o}, 3'h0, "reset flags");
    reset_n <= 1'b1;
    rd(A_CTL, 32'ha0);
    rd(A_MSK, 32'h0);
    foreach (rows[i]) begin
      wr(A_CTL, rows[i].wr);
      wait_cyc(2);
      chk(outs, rows[i].outs, "row outputs");
      rd(A_CTL, {24'h0, rows[i].rd});
    end
    rd(A_STA, 32'h4);
    rd(A_STA, 32'h0);
    // Each reserved code refused, flagged and raised on the interrupt
    wr(A_CTL, 8'ha0);
    wr(A_MSK, 8'h04);
    for (int k = 0; k < 4; k++) begin
      wr(A_CTL, {5'h14, bad_codes[k]});
      wait_cyc(3);
      chk(irq, 1'b1, "irq on reserved code");
      rd(A_STA, 32'h4);
      wait_cyc(3);
      chk(irq, 1'b0, "irq after clear");
      rd(A_CTL, 32'ha0);
    end
    // Byte lane off, unmapped place: both leave the control alone
    begin
      logic [31:0] q;
      wb(1'b1, A_CTL, 8'h01, 4'he, q);
    end
    wr(16'h3e24, 8'h01);
    rd(16'h3e24, 32'h0);
    rd(A_CTL, 32'ha0);
    // External pin followed only while selected
    wr(A_CTL, 8'ha4);
    for (int k = 0; k < 3; k++) begin
      external_clock_input_pin <= (k != 1);
      wait_cyc(8);
      chk(ext_clock_level, k != 1, "pin level");
    end
    wr(A_CTL, 8'ha0);
    wait_cyc(3);
    chk(ext_clock_level, 1'b0, "pin deselected");
    // Watchdog failure ignored while disabled, caught when enabled
    wr(A_MSK, 8'h03);
    wr(A_CTL, 8'ha3);
    watchdog_osc_fail <= 1'b1;
    primary_osc_fail  <= 1'b1;
    wait_cyc(10);
    chk(irq, 1'b0, "fails while detect disabled");
    chk(outs, 6'h33, "primary fail disabled");
    watchdog_osc_fail <= 1'b0;
    primary_osc_fail  <= 1'b0;
    wait_cyc(8);
    wr(A_CTL, 8'hab);
    watchdog_osc_fail <= 1'b1;
    wait_cyc(10);
    chk(irq, 1'b1, "wdt fail irq");
    rd(A_STA, 32'h2);
    watchdog_osc_fail <= 1'b0;
    // Primary failure forces internal oscillator at the fast rate
    wr(A_CTL, 8'h33);
    wait_cyc(2);
    chk(outs, 6'h13, "before primary fail");
    primary_osc_fail <= 1'b1;
    wait_cyc(10);
    chk(outs, 6'h30, "primary recovery");
    rd(A_STA, 32'h1);
    rd(A_CTL, 32'hb0);
    primary_osc_fail <= 1'b0;
    wait_cyc(4);
    // Second reset in mid-run brings every output back
    wr(A_CTL, 8'h01);
    wait_cyc(2);
    chk(outs, 6'h09, "before mid-run reset");
    reset_n <= 1'b0;
    wait_cyc(2);
    chk(outs, 6'h30, "mid-run reset outputs");
    chk({ext_clock_level, irq, wb_ack_o}, 3'h0, "mid-run reset flags");
    reset_n <= 1'b1;
    rd(A_CTL, 32'ha0);
    rd(A_MSK, 32'h0);
    test_done();
  end
endmodule // testbench
`default_nettype wire
